// [sim/ads_checker.sv]
// port assertions of the adc sample controller
`timescale 1ns/1ps
`default_nettype none
module ads_checker #(
	parameter int unsigned RAW_W = 10
) (
	input wire logic             clk,
	input wire logic             rst,
	input wire logic [3:0]       reg_addr,
	input wire logic [15:0]      reg_wdata,
	input wire logic             reg_wr,
	input wire logic             reg_rd,
	input wire logic [15:0]      reg_rdata,
	input wire logic [RAW_W-1:0] core_code,
	input wire logic             core_start,
	input wire logic [5:0]       core_pin,
	input wire logic [2:0]       core_mode,
	input wire logic [1:0]       core_range,
	input wire logic             core_ref_bg,
	input wire logic [9:0]       pad_pin_en,
	input wire logic [15:0]      sample_data,
	input wire logic             sample_valid
);
	logic [11:0] gap_reg;
	logic [11:0] cfg_reg;
	logic [11:0] lat_w;
	logic        cfg_wr_w;
	assign cfg_wr_w = reg_wr && (reg_addr == ads_pkg::REG_CTRL
		|| (reg_addr == ads_pkg::REG_CHAN && reg_wdata[3:0] <= 4'h8));
	assign lat_w = (core_mode == 3'h0) ? ads_pkg::LAT_M0_CYC
		: (core_mode == 3'h1) ? ads_pkg::LAT_M1_CYC
		: (core_mode == 3'h2) ? ads_pkg::LAT_M2_CYC
		: (core_mode == 3'h3) ? ads_pkg::LAT_M3_CYC : ads_pkg::LAT_M4_CYC;
	// saturating cycle counts since last sample and last config change
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gap_reg <= 12'hfff;
			cfg_reg <= 12'hfff;
		end else begin
			gap_reg <= sample_valid ? 12'h0 : gap_reg + {11'h0, ~&gap_reg};
			cfg_reg <= cfg_wr_w ? 12'h0 : cfg_reg + {11'h0, ~&cfg_reg};
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	chk_valid_pipe: assert property (sample_valid |-> $past(core_start, 201))
		else $error("sample not 201 cycles after a start");
	chk_rate_gap: assert property (sample_valid |-> gap_reg >= 12'h06a)
		else $error("samples closer than the fastest period");
	chk_settle_wait: assert property (
		sample_valid && cfg_reg != 12'h0 |-> cfg_reg >= lat_w)
		else $error("sample delivered while settling");
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
		else $error("read data outside its cycle");
	chk_data_hold: assert property (!sample_valid |-> $stable(sample_data))
		else $error("sample data changed without strobe");
	chk_mode_clamp: assert property (core_mode <= ads_pkg::MODE_MAX)
		else $error("mode above four");
	chk_pad_single: assert property (
		((pad_pin_en ^ (pad_pin_en >> 1)) & 10'h155) == 10'h155)
		else $error("dual pad without exactly one pin");
	chk_crystal_pin: assert property (
		(core_pin == ads_pkg::PIN_P11 |-> pad_pin_en[2])
		and (core_pin == ads_pkg::PIN_P12 |-> pad_pin_en[4]))
		else $error("crystal pad routed from wrong pin");
	chk_pin_legal: assert property (core_pin inside {6'h00, 6'h01, 6'h08,
		6'h21, 6'h0b, 6'h0c, 6'h0d, 6'h1c, 6'h0e, 6'h26, 6'h0f, 6'h20})
		else $error("pin not converter capable");
	chk_range_legal: assert property (core_range != 2'h3)
		else $error("reserved range code");
	chk_word_low: assert property (
		sample_valid |-> sample_data[15-RAW_W:0] == '0)
		else $error("sample low bits not zero");
endmodule
bind ads_sample_controller ads_checker #(.RAW_W(RAW_W)) u_chk (
	.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.core_code(core_code), .core_start(core_start), .core_pin(core_pin),
	.core_mode(core_mode), .core_range(core_range),
	.core_ref_bg(core_ref_bg), .pad_pin_en(pad_pin_en),
	.sample_data(sample_data), .sample_valid(sample_valid)
);
`default_nettype wire

// [sim/ads_core_model.sv]
// behavioural model of the analog converter core
`timescale 1ns/1ps
`default_nettype none
module ads_core_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       core_start,
	input  wire logic [5:0] core_pin,
	output logic      [9:0] core_code
);
	logic [9:0] code_reg;
	logic [7:0] busy_reg;
	// code holds through one conversion, else the line toggles
	assign core_code = (busy_reg != 8'h0) ? code_reg : ~code_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			code_reg <= 10'h0;
			busy_reg <= 8'h0;
		end else if (core_start) begin
			code_reg <= 10'h140 + {4'h0, core_pin};
			busy_reg <= 8'hca;
		end else if (busy_reg != 8'h0) begin
			busy_reg <= busy_reg - 8'h1;
		end else begin
			code_reg <= ~code_reg;
		end
	end
endmodule
`default_nettype wire

// [sim/testbench.sv]
// self-checking bench of the adc sample controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic [9:0]  core_code;
	logic        core_start;
	logic [5:0]  core_pin;
	logic [2:0]  core_mode;
	logic [1:0]  core_range;
	logic        core_ref_bg;
	logic [9:0]  pad_pin_en;
	logic [15:0] sample_data;
	logic        sample_valid;
	int          num_errors = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	logic [5:0]  pins [9] = '{6'h00, 6'h01, 6'h08, 6'h0b, 6'h0c,
		6'h0d, 6'h0e, 6'h0f, 6'h20};
	always #25 clk = ~clk;
	ads_sample_controller uut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .core_code(core_code),
		.core_start(core_start), .core_pin(core_pin), .core_mode(core_mode),
		.core_range(core_range), .core_ref_bg(core_ref_bg),
		.pad_pin_en(pad_pin_en), .sample_data(sample_data),
		.sample_valid(sample_valid));
	ads_core_model core (.clk(clk), .rst(rst), .core_start(core_start),
		.core_pin(core_pin), .core_code(core_code));
	// --------
	// helpers
	// --------
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(negedge clk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask
	task automatic wait_hi(input bit smp, input int lim, output int n);
		n = 0;
		while ((smp ? sample_valid : core_start) !== 1'b1 && n < lim) begin
			@(negedge clk);
			n++;
		end
		if (n >= lim) check(16'h0, 16'h1);
	endtask
	// --------
	// scenarios
	// --------
	task automatic t_reset;
		logic [15:0] r;
		rd(ads_pkg::REG_CTRL, r);
		check(r, 16'h0040);
		rd(ads_pkg::REG_CHAN, r);
		check(r, 16'h0000);
		wr(4'h7, 16'hffff);
		rd(4'h7, r);
		check(r, 16'h0000);
		rd(ads_pkg::REG_CTRL, r);
		check(r, 16'h0040);
		check({13'h0, core_mode}, 16'h0004);
		check({6'h0, pad_pin_en}, 16'h0155);
	endtask
	task automatic t_modes;
		logic [15:0] r;
		logic [2:0]  em;
		for (int m = 0; m < 8; m++) begin
			wr(ads_pkg::REG_CTRL, 16'(m << 4) | 16'h0001);
			em = (m > 4) ? 3'h4 : 3'(m);
			check({13'h0, core_mode}, {13'h0, em});
			rd(ads_pkg::REG_STATUS, r);
			check(r & 16'h001e, {11'h0, em, 2'h2});
		end
	endtask
	task automatic t_period(input logic [2:0] m, input int rate);
		int n;
		wr(ads_pkg::REG_CTRL, {9'h0, m, 4'h1});
		wait_hi(1'b0, 10, n);
		@(negedge clk);
		wait_hi(1'b0, 4000, n);
		check(16'(n + 1), 16'((ads_pkg::CLK_HZ + rate - 1) / rate));
	endtask
	task automatic t_range;
		for (int k = 0; k < 8; k++) begin
			wr(ads_pkg::REG_CTRL, 16'(k << 1));
			check({14'h0, core_range}, (k >> 1) == 3 ? 16'h0 : 16'(k >> 1));
			check({15'h0, core_ref_bg}, 16'(k & 1));
		end
	endtask
	task automatic t_chan;
		for (int i = 0; i < 9; i++) begin
			wr(ads_pkg::REG_CHAN, 16'(i));
			check({10'h0, core_pin}, {10'h0, pins[i]});
		end
		wr(ads_pkg::REG_CHAN, 16'h0012);
		check({10'h0, core_pin}, 16'h0021);
		wr(ads_pkg::REG_CHAN, 16'h0085);
		check({10'h0, core_pin}, 16'h001c);
		wr(ads_pkg::REG_CHAN, 16'h0106);
		check({10'h0, core_pin}, 16'h0026);
		wr(ads_pkg::REG_CHAN, 16'h0009);
		check({10'h0, core_pin}, 16'h0026);
		wr(ads_pkg::REG_CHAN, 16'h0063);
		check({10'h0, core_pin}, 16'h000b);
		check({6'h0, pad_pin_en}, 16'h0165);
		wr(ads_pkg::REG_CHAN, 16'h0064);
		check({10'h0, core_pin}, 16'h000c);
		check({6'h0, pad_pin_en}, 16'h0159);
	endtask
	task automatic t_sample(input logic [3:0] ch, input logic [9:0] off,
		input logic [2:0] m, input int lat, input int exp_n);
		logic [15:0] r;
		logic [15:0] e;
		logic [9:0]  code;
		int          n;
		code = 10'h140 + {4'h0, pins[ch]};
		e = (code > off) ? {code - off, 6'h0} : 16'h0;
		wr(ads_pkg::REG_OFFSET, {6'h0, off});
		wr(ads_pkg::REG_CHAN, {12'h0, ch});
		wr(ads_pkg::REG_CTRL, {9'h0, m, 4'h1});
		wait_hi(1'b1, 1000, n);
		check(sample_data, e);
		check(16'(n), 16'(exp_n));
		check(16'(n > lat), 16'h1);
		rd(ads_pkg::REG_STATUS, r);
		check(r & 16'h0020, 16'h0020);
		rd(ads_pkg::REG_SAMPLE, r);
		check(r, e);
		rd(ads_pkg::REG_STATUS, r);
		check(r & 16'h0020, 16'h0000);
	endtask
	task automatic t_stop;
		int hits;
		hits = 0;
		wr(ads_pkg::REG_CTRL, 16'h0040);
		repeat (300) begin
			@(negedge clk);
			if (core_start === 1'b1 || sample_valid === 1'b1) hits++;
		end
		check(16'(hits), 16'h0);
	endtask
	task automatic tally_and_finish;
		if (num_errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_modes();
		t_period(3'h4, 187000);
		t_period(3'h3, 93750);
		t_period(3'h2, 46875);
		t_period(3'h1, 11700);
		t_period(3'h0, 5859);
		t_range();
		t_chan();
		t_sample(4'h8, 10'h010, 3'h4, ads_pkg::LAT_M4_CYC,
			ads_pkg::CONV_CYC + 1);
		// first result falls inside settling and is dropped
		t_sample(4'h3, 10'h3ff, 3'h2, ads_pkg::LAT_M2_CYC,
			ads_pkg::CONV_CYC + ads_pkg::PER_M2_CYC + 1);
		t_stop();
		tally_and_finish();
	end
endmodule
`default_nettype wire

// [verilog/ads_pkg.sv]
// constants, register map and timing for the adc sample controller
package ads_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ   = 20_000_000;
	localparam int unsigned CLK_MHZ  = CLK_HZ / 1_000_000;
	localparam int unsigned CONV_US  = 10;
	localparam int unsigned CONV_CYC = CONV_US * CLK_MHZ;

	localparam int unsigned LAT_M0_US = 171;
	localparam int unsigned LAT_M1_US = 85;
	localparam int unsigned LAT_M2_US = 21;
	localparam int unsigned LAT_M3_US = 11;
	localparam int unsigned LAT_M4_US = 5;

	localparam int unsigned RATE_M0_HZ = 5859;
	localparam int unsigned RATE_M1_HZ = 11700;
	localparam int unsigned RATE_M2_HZ = 46875;
	localparam int unsigned RATE_M3_HZ = 93750;
	localparam int unsigned RATE_M4_HZ = 187000;

	localparam int unsigned CNT_W = 12;
	typedef logic [CNT_W-1:0] ads_cnt_t;

	// settling counts, least time so whole cycles suffice
	localparam ads_cnt_t LAT_M0_CYC = CNT_W'(LAT_M0_US * CLK_MHZ);
	localparam ads_cnt_t LAT_M1_CYC = CNT_W'(LAT_M1_US * CLK_MHZ);
	localparam ads_cnt_t LAT_M2_CYC = CNT_W'(LAT_M2_US * CLK_MHZ);
	localparam ads_cnt_t LAT_M3_CYC = CNT_W'(LAT_M3_US * CLK_MHZ);
	localparam ads_cnt_t LAT_M4_CYC = CNT_W'(LAT_M4_US * CLK_MHZ);

	// sample periods rounded up so the rate is never exceeded
	localparam ads_cnt_t PER_M0_CYC = CNT_W'((CLK_HZ + RATE_M0_HZ - 1) / RATE_M0_HZ);
	localparam ads_cnt_t PER_M1_CYC = CNT_W'((CLK_HZ + RATE_M1_HZ - 1) / RATE_M1_HZ);
	localparam ads_cnt_t PER_M2_CYC = CNT_W'((CLK_HZ + RATE_M2_HZ - 1) / RATE_M2_HZ);
	localparam ads_cnt_t PER_M3_CYC = CNT_W'((CLK_HZ + RATE_M3_HZ - 1) / RATE_M3_HZ);
	localparam ads_cnt_t PER_M4_CYC = CNT_W'((CLK_HZ + RATE_M4_HZ - 1) / RATE_M4_HZ);

	// ----------------------------------------------------------------
	// modes, ranges, channels
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_MAX   = 3'h4;
	localparam logic [1:0] RANGE_3V6  = 2'h0;
	localparam logic [1:0] RANGE_2V4  = 2'h1;
	localparam logic [1:0] RANGE_1V2  = 2'h2;
	localparam logic [3:0] CHAN_MAX   = 4'h8;
	localparam int unsigned NPAD      = 5;
	localparam int unsigned SAMPLE_W  = 16;

	// pad slots of the dual-bonded pads
	localparam int unsigned PAD_17 = 0;
	localparam int unsigned PAD_4  = 1;
	localparam int unsigned PAD_5  = 2;
	localparam int unsigned PAD_8  = 3;
	localparam int unsigned PAD_7  = 4;

	// port pin numbers handed to the analog mux
	localparam logic [5:0] PIN_P0  = 6'h00;
	localparam logic [5:0] PIN_P1  = 6'h01;
	localparam logic [5:0] PIN_P8  = 6'h08;
	localparam logic [5:0] PIN_P33 = 6'h21;
	localparam logic [5:0] PIN_P11 = 6'h0b;
	localparam logic [5:0] PIN_P12 = 6'h0c;
	localparam logic [5:0] PIN_P13 = 6'h0d;
	localparam logic [5:0] PIN_P28 = 6'h1c;
	localparam logic [5:0] PIN_P14 = 6'h0e;
	localparam logic [5:0] PIN_P38 = 6'h26;
	localparam logic [5:0] PIN_P15 = 6'h0f;
	localparam logic [5:0] PIN_P32 = 6'h20;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_CHAN   = 4'h1;
	localparam logic [3:0] REG_OFFSET = 4'h2;
	localparam logic [3:0] REG_STATUS = 4'h3;
	localparam logic [3:0] REG_SAMPLE = 4'h4;

	localparam int unsigned CTRL_EN_POS    = 0;
	localparam int unsigned CTRL_REF_POS   = 1;
	localparam int unsigned CTRL_RANGE_POS = 2;
	localparam int unsigned CTRL_MODE_POS  = 4;
	localparam int unsigned CHAN_SEL_POS   = 0;
	localparam int unsigned CHAN_ALT_POS   = 4;

	localparam logic [15:0] CTRL_RST   = 16'h0040;
	localparam logic [15:0] CHAN_RST   = 16'h0000;
	localparam logic [15:0] OFFSET_RST = 16'h0000;

	function automatic ads_cnt_t lat_cyc(input logic [2:0] m);
		case (m)
			3'h0:    lat_cyc = LAT_M0_CYC;
			3'h1:    lat_cyc = LAT_M1_CYC;
			3'h2:    lat_cyc = LAT_M2_CYC;
			3'h3:    lat_cyc = LAT_M3_CYC;
			default: lat_cyc = LAT_M4_CYC;
		endcase
	endfunction

	function automatic ads_cnt_t per_cyc(input logic [2:0] m);
		case (m)
			3'h0:    per_cyc = PER_M0_CYC;
			3'h1:    per_cyc = PER_M1_CYC;
			3'h2:    per_cyc = PER_M2_CYC;
			3'h3:    per_cyc = PER_M3_CYC;
			default: per_cyc = PER_M4_CYC;
		endcase
	endfunction

endpackage

// [verilog/ads_sample_controller.sv]
// adc sample controller: registers, channel and pad mux, sample path
`timescale 1ns/1ps
`default_nettype none
module ads_sample_controller #(
	parameter int unsigned RAW_W = 10
) (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic [3:0]           reg_addr,
	input  wire logic [15:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [15:0]          reg_rdata,
	input  wire logic [RAW_W-1:0]     core_code,
	output logic                      core_start,
	output logic      [5:0]           core_pin,
	output logic      [2:0]           core_mode,
	output logic      [1:0]           core_range,
	output logic                      core_ref_bg,
	output logic      [2*ads_pkg::NPAD-1:0] pad_pin_en,
	output logic      [15:0]          sample_data,
	output logic                      sample_valid
);

	// ----------------------------------------------------------------
	// parameter check
	// ----------------------------------------------------------------
	if (RAW_W < 1 || RAW_W > ads_pkg::SAMPLE_W) begin : g_chk
		$error("RAW_W must lie between 1 and 16");
	end

	localparam int unsigned SHIFT = ads_pkg::SAMPLE_W - RAW_W;
	localparam int unsigned CONV  = ads_pkg::CONV_CYC;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	ads_tim_if tif ();

	logic [15:0]            ctrl_reg;
	logic [3:0]             chan_reg;
	logic [ads_pkg::NPAD-1:0] alt_reg;
	logic [RAW_W-1:0]       offs_reg;
	logic [15:0]            rdata_reg;
	logic [15:0]            sample_reg;
	logic                   valid_reg;
	logic                   fresh_reg;
	logic                   fresh_next;
	logic [CONV-1:0]        pipe_reg;
	logic [CONV-1:0]        pipe_next;

	wire logic              wr_ctrl;
	wire logic              wr_chan;
	wire logic              wr_offs;
	wire logic              rd_sample;
	wire logic              chan_ok;
	wire logic              en;
	wire logic [2:0]        mode_raw;
	wire logic [2:0]        mode_eff;
	wire logic [1:0]        range_raw;
	wire logic [1:0]        range_eff;
	wire logic [ads_pkg::NPAD-1:0] alt_eff;
	wire logic [5:0]        pin_sel;
	wire logic              done;
	wire logic [RAW_W-1:0]  diff;
	wire logic [15:0]       proc_word;
	wire logic [15:0]       status_word;
	wire logic [15:0]       rd_mux;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	assign wr_ctrl   = reg_wr && (reg_addr == ads_pkg::REG_CTRL);
	assign wr_chan   = reg_wr && (reg_addr == ads_pkg::REG_CHAN);
	assign wr_offs   = reg_wr && (reg_addr == ads_pkg::REG_OFFSET);
	assign rd_sample = reg_rd && (reg_addr == ads_pkg::REG_SAMPLE);

	// out-of-range channel codes are refused, the old channel stays
	assign chan_ok = (reg_wdata[ads_pkg::CHAN_SEL_POS +: 4]
		<= ads_pkg::CHAN_MAX);

	// ----------------------------------------------------------------
	// configuration fields
	// ----------------------------------------------------------------
	assign en        = ctrl_reg[ads_pkg::CTRL_EN_POS];
	assign mode_raw  = ctrl_reg[ads_pkg::CTRL_MODE_POS +: 3];
	assign mode_eff  = (mode_raw > ads_pkg::MODE_MAX) ?
		ads_pkg::MODE_MAX : mode_raw;
	assign range_raw = ctrl_reg[ads_pkg::CTRL_RANGE_POS +: 2];
	// reserved range code falls back to the widest range
	assign range_eff = (range_raw > ads_pkg::RANGE_1V2) ?
		ads_pkg::RANGE_3V6 : range_raw;

	assign core_mode   = mode_eff;
	assign core_range  = range_eff;
	assign core_ref_bg = ctrl_reg[ads_pkg::CTRL_REF_POS];

	// ----------------------------------------------------------------
	// pad ownership and channel to pin mapping
	// ----------------------------------------------------------------
	// select-one pads take either bonded pin
	assign alt_eff[ads_pkg::PAD_17] = alt_reg[ads_pkg::PAD_17];
	assign alt_eff[ads_pkg::PAD_8]  = alt_reg[ads_pkg::PAD_8];
	assign alt_eff[ads_pkg::PAD_7]  = alt_reg[ads_pkg::PAD_7];
	// crystal pads feed the converter only from their designated pin
	assign alt_eff[ads_pkg::PAD_4]  = (chan_reg == 4'h3) ?
		1'b0 : alt_reg[ads_pkg::PAD_4];
	assign alt_eff[ads_pkg::PAD_5]  = (chan_reg == 4'h4) ?
		1'b0 : alt_reg[ads_pkg::PAD_5];

	genvar gi;
	generate
		for (gi = 0; gi < ads_pkg::NPAD; gi++) begin : g_pad
			// exactly one of the two bonded pins is live
			assign pad_pin_en[2*gi]   = ~alt_eff[gi];
			assign pad_pin_en[2*gi+1] =  alt_eff[gi];
		end
	endgenerate

	assign pin_sel =
		(chan_reg == 4'h0) ? ads_pkg::PIN_P0 :
		(chan_reg == 4'h1) ? ads_pkg::PIN_P1 :
		(chan_reg == 4'h2) ? (alt_eff[ads_pkg::PAD_17] ?
			ads_pkg::PIN_P33 : ads_pkg::PIN_P8) :
		(chan_reg == 4'h3) ? ads_pkg::PIN_P11 :
		(chan_reg == 4'h4) ? ads_pkg::PIN_P12 :
		(chan_reg == 4'h5) ? (alt_eff[ads_pkg::PAD_8] ?
			ads_pkg::PIN_P28 : ads_pkg::PIN_P13) :
		(chan_reg == 4'h6) ? (alt_eff[ads_pkg::PAD_7] ?
			ads_pkg::PIN_P38 : ads_pkg::PIN_P14) :
		(chan_reg == 4'h7) ? ads_pkg::PIN_P15 :
		ads_pkg::PIN_P32;
	assign core_pin = pin_sel;

	// ----------------------------------------------------------------
	// timer hookup
	// ----------------------------------------------------------------
	assign tif.run        = en;
	// any control write or accepted channel write, and enabling, restarts settling
	assign tif.cfg_change = wr_ctrl || (wr_chan && chan_ok);
	assign tif.mode       = wr_ctrl ?
		((reg_wdata[ads_pkg::CTRL_MODE_POS +: 3] > ads_pkg::MODE_MAX) ?
		ads_pkg::MODE_MAX : reg_wdata[ads_pkg::CTRL_MODE_POS +: 3]) :
		mode_eff;

	ads_timer u_timer (
		.clk (clk),
		.rst (rst),
		.t   (tif.tim)
	);

	assign core_start = tif.start;

	// ----------------------------------------------------------------
	// conversion latency and post-processing
	// ----------------------------------------------------------------
	// a change flushes conversions still in flight on the old setup
	assign pipe_next = tif.cfg_change ? '0 :
		{pipe_reg[CONV-2:0], tif.start};
	assign done      = pipe_reg[CONV-1];

	// remove offset with floor at zero, then left-justify to 16 bits
	assign diff      = (core_code > offs_reg) ?
		core_code - offs_reg : '0;
	assign proc_word = {diff, {SHIFT{1'b0}}};

	// ----------------------------------------------------------------
	// status and readback
	// ----------------------------------------------------------------
	// new-sample flag: set beats a clearing read
	assign fresh_next = (done && !tif.settling) ? 1'b1 :
		rd_sample ? 1'b0 : fresh_reg;

	assign status_word = {10'h000, fresh_reg, mode_eff,
		en, tif.settling};

	assign rd_mux =
		(reg_addr == ads_pkg::REG_CTRL)   ? ctrl_reg :
		(reg_addr == ads_pkg::REG_CHAN)   ?
			{7'h00, alt_reg, chan_reg} :
		(reg_addr == ads_pkg::REG_OFFSET) ?
			16'(offs_reg) :
		(reg_addr == ads_pkg::REG_STATUS) ? status_word :
		(reg_addr == ads_pkg::REG_SAMPLE) ? sample_reg :
		16'h0000;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= ads_pkg::CTRL_RST;
			chan_reg <= ads_pkg::CHAN_RST[3:0];
			alt_reg  <= ads_pkg::CHAN_RST[ads_pkg::CHAN_ALT_POS +: ads_pkg::NPAD];
			offs_reg <= ads_pkg::OFFSET_RST[RAW_W-1:0];
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= {9'h000, reg_wdata[6:0]};
			end
			if (wr_chan && chan_ok) begin
				chan_reg <= reg_wdata[ads_pkg::CHAN_SEL_POS +: 4];
				alt_reg  <= reg_wdata[ads_pkg::CHAN_ALT_POS +: ads_pkg::NPAD];
			end
			if (wr_offs) begin
				offs_reg <= reg_wdata[RAW_W-1:0];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pipe_reg   <= '0;
			sample_reg <= '0;
			valid_reg  <= 1'b0;
			fresh_reg  <= 1'b0;
		end else begin
			pipe_reg   <= pipe_next;
			valid_reg  <= done && !tif.settling;
			fresh_reg  <= fresh_next;
			if (done && !tif.settling) begin
				sample_reg <= proc_word;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_reg <= 16'h0000;
		end else begin
			rdata_reg <= reg_rd ? rd_mux : 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata    = rdata_reg;
	assign sample_data  = sample_reg;
	assign sample_valid = valid_reg;

endmodule
`default_nettype wire

// [verilog/ads_tim_if.sv]
// control and timing signals between the controller and its timer
`timescale 1ns/1ps
`default_nettype none
interface ads_tim_if;
	logic       run;
	logic       cfg_change;
	logic [2:0] mode;
	logic       start;
	logic       settling;

	modport ctl (output run, output cfg_change, output mode,
		input start, input settling);
	modport tim (input run, input cfg_change, input mode,
		output start, output settling);
endinterface
`default_nettype wire

// [verilog/ads_timer.sv]
// settling and sample-rate timer of the adc sample controller
`timescale 1ns/1ps
`default_nettype none
module ads_timer (
	input  wire logic clk,
	input  wire logic rst,
	ads_tim_if.tim    t
);

	ads_pkg::ads_cnt_t settle_reg;
	ads_pkg::ads_cnt_t settle_next;
	ads_pkg::ads_cnt_t rate_reg;
	ads_pkg::ads_cnt_t rate_next;
	wire  logic        rate_hit;

	// ----------------------------------------------------------------
	// settling: reload on any change, count down to zero
	// ----------------------------------------------------------------
	assign settle_next = t.cfg_change ? ads_pkg::lat_cyc(t.mode) :
		(settle_reg != '0) ? settle_reg - 1'b1 : settle_reg;
	assign t.settling = (settle_reg != '0);

	// ----------------------------------------------------------------
	// start pacing at the mode's period
	// ----------------------------------------------------------------
	assign rate_hit  = t.run && (rate_reg == '0);
	assign rate_next = (!t.run || t.cfg_change) ? '0 :
		rate_hit ? ads_pkg::per_cyc(t.mode) - 1'b1 : rate_reg - 1'b1;
	assign t.start   = rate_hit && !t.cfg_change;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			settle_reg <= '0;
			rate_reg   <= '0;
		end else begin
			settle_reg <= settle_next;
			rate_reg   <= rate_next;
		end
	end

endmodule
`default_nettype wire
